// ==== verilog/pfhc_pkg.sv ====
package pfhc_pkg;
  // Bus cycle timing at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDRESS_ACCESS_LATENCY_NS = 90;
  localparam int PAGE_ACCESS_LATENCY_NS = 25;
  localparam int WRITE_PULSE_NS = 35;
  localparam int WRITE_HIGH_NS = 20;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_RECOVER_NS = 50;
  localparam int ACC_CYC = (ADDRESS_ACCESS_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PACC_CYC = (PAGE_ACCESS_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC = (WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // Page geometry
  localparam int PAGE_WORD_BITS = 3;
  // Command words
  localparam logic [23:0] UNLOCK_ADDR1 = 24'h000555;
  localparam logic [23:0] UNLOCK_ADDR2 = 24'h0002aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_IDENT = 16'h0090;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [7:0] POLL_LIMIT = 8'hff;
  // Host operations
  typedef enum logic [2:0] {
    PFHC_OP_READ    = 3'b000,
    PFHC_OP_PROGRAM = 3'b001,
    PFHC_OP_IDENT   = 3'b010,
    PFHC_OP_EXIT_ID = 3'b011,
    PFHC_OP_HWRESET = 3'b100
  } pfhc_op_t;
endpackage

// ==== verilog/pfhc_cyc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface pfhc_cyc_if;
  logic        start;
  logic        is_write;
  logic        keep_sel;
  logic [3:0]  wait_cyc;
  logic [23:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport seq (output start, is_write, keep_sel, wait_cyc, addr, wdata, input done, rdata);
  modport eng (input start, is_write, keep_sel, wait_cyc, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ==== verilog/pfhc_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfhc_cycle
  import pfhc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Sequencer side
  pfhc_cyc_if.eng          cyc,
  // Pin side, registered
  input  wire logic [15:0] dq_sync,
  output logic             sel_n,
  output logic             gate_n,
  output logic             wstrb_n,
  output logic [23:0]      addr_pin,
  output logic [15:0]      dq_o,
  output logic             dq_oe
);
  typedef enum logic [1:0] {
    PFHC_CY_IDLE = 2'b00,
    PFHC_CY_ACT  = 2'b01,
    PFHC_CY_HOLD = 2'b10,
    PFHC_CY_SETUP = 2'b11
  } pfhc_cy_t;
  pfhc_cy_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic sel_q, next_sel, gate_q, next_gate, we_q, next_we, oe_q, next_oe, done_q, next_done;
  logic [23:0] a_q, next_a;
  logic [15:0] d_q, next_d, r_q, next_r;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_sel = sel_q;
    next_gate = gate_q;
    next_we = we_q;
    next_oe = oe_q;
    next_a = a_q;
    next_d = d_q;
    next_r = r_q;
    next_done = 1'b0;
    case (st)
      PFHC_CY_IDLE: begin
        if (cyc.start) begin
          next_a = cyc.addr;
          next_d = cyc.wdata;
          next_sel = 1'b0;
          next_cnt = cyc.wait_cyc;
          next_st = PFHC_CY_ACT;
          if (cyc.is_write) begin
            // Strobe waits a cycle so the address settles first
            next_gate = 1'b1;
            next_oe = 1'b1;
            next_st = PFHC_CY_SETUP;
          end else begin
            // Sync flops lag the pins; one extra cycle covers them
            next_cnt = cyc.wait_cyc + 4'h1;
            next_gate = 1'b0;
            next_we = 1'b1;
            next_oe = 1'b0;
          end
        end
      end
      PFHC_CY_SETUP: begin
        next_we = 1'b0;
        next_st = PFHC_CY_ACT;
      end
      PFHC_CY_ACT: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          // Data taken on the first rising strobe edge
          next_r = dq_sync;
          next_we = 1'b1;
          next_gate = 1'b1;
          next_sel = !cyc.keep_sel;
          next_cnt = 4'(WH_CYC);
          next_st = PFHC_CY_HOLD;
        end
      end
      PFHC_CY_HOLD: begin
        // Data held past strobe release for device hold time
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_oe = 1'b0;
          next_done = 1'b1;
          next_st = PFHC_CY_IDLE;
        end
      end
      default: next_st = PFHC_CY_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= PFHC_CY_IDLE;
      cnt <= 4'h0;
      sel_q <= 1'b1;
      gate_q <= 1'b1;
      we_q <= 1'b1;
      oe_q <= 1'b0;
      a_q <= 24'h000000;
      d_q <= 16'h0000;
      r_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      sel_q <= next_sel;
      gate_q <= next_gate;
      we_q <= next_we;
      oe_q <= next_oe;
      a_q <= next_a;
      d_q <= next_d;
      r_q <= next_r;
      done_q <= next_done;
    end
  end

  assign sel_n = sel_q;
  assign gate_n = gate_q;
  assign wstrb_n = we_q;
  assign addr_pin = a_q;
  assign dq_o = d_q;
  assign dq_oe = oe_q;
  assign cyc.done = done_q;
  assign cyc.rdata = r_q;
endmodule
`default_nettype wire

// ==== verilog/pfhc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfhc_top
  import pfhc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Host request port
  input  wire logic        req_valid,
  input  wire pfhc_op_t    req_op,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic        word_mode,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_error,
  output logic             id_active,
  // Flash pins
  output logic             flash_sel_n,
  output logic             flash_gate_n,
  output logic             flash_wstrb_n,
  output logic             flash_reset_n,
  output logic             flash_width_sel,
  output logic [23:0]      flash_addr,
  input  wire logic [15:0] flash_dq_i,
  output logic [15:0]      flash_dq_o,
  output logic [15:0]      flash_dq_oe
);
  typedef enum logic [2:0] {
    PFHC_S_IDLE  = 3'b000,
    PFHC_S_CYC   = 3'b001,
    PFHC_S_WAIT  = 3'b010,
    PFHC_S_POLL  = 3'b011,
    PFHC_S_RSTLO = 3'b100,
    PFHC_S_RSTHI = 3'b101
  } pfhc_state_t;

  pfhc_cyc_if cyc ();
  logic [15:0] dq_meta, dq_sync;
  logic [15:0] dq_o_raw;
  logic        dq_oe_raw;
  pfhc_state_t st, next_st;
  pfhc_op_t    op, next_op;
  logic [1:0]  step, next_step;
  logic [23:0] addr_q, next_addr;
  logic [15:0] data_q, next_data;
  logic [15:0] prev_poll, next_prev_poll;
  logic [7:0]  cnt, next_cnt;
  logic        rdy, next_rdy, vld, next_vld, err, next_err, idm, next_idm;
  logic        rstn, next_rstn, wm, next_wm, pg_ok, next_pg_ok;
  logic [15:0] rd, next_rd;
  logic [20:0] page_q, next_page;
  logic        start, next_start, isw, next_isw, keep, next_keep;
  logic [3:0]  wc, next_wc;
  logic [23:0] ca, next_ca;
  logic [15:0] cd, next_cd;
  logic        alsb, next_alsb;
  logic [20:0] req_page;

  // Pins from outside pass two flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= flash_dq_i;
      dq_sync <= dq_meta;
    end
  end

  pfhc_cycle u_cycle (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .cyc      (cyc.eng),
    .dq_sync  (dq_sync),
    .sel_n    (flash_sel_n),
    .gate_n   (flash_gate_n),
    .wstrb_n  (flash_wstrb_n),
    .addr_pin (flash_addr),
    .dq_o     (dq_o_raw),
    .dq_oe    (dq_oe_raw)
  );

  assign cyc.start = start;
  assign cyc.is_write = isw;
  assign cyc.keep_sel = keep;
  assign cyc.wait_cyc = wc;
  assign cyc.addr = ca;
  assign cyc.wdata = cd;
  // Byte mode: pin 15 is an address input, so it is always driven
  assign flash_dq_o = wm ? dq_o_raw : {alsb, 7'h00, dq_o_raw[7:0]};
  assign flash_dq_oe = wm ? {16{dq_oe_raw}} : {1'b1, 7'h00, {8{dq_oe_raw}}};
  assign req_page = word_mode ? req_addr[23:PAGE_WORD_BITS] :
                    {1'b0, req_addr[23:PAGE_WORD_BITS + 1]};

  // Command step address/data for program and identifier sequences
  function automatic logic [39:0] pfhc_cmd(input logic [1:0] s, input logic [15:0] last,
                                           input logic [23:0] a);
    case (s)
      2'd0: pfhc_cmd = {UNLOCK_ADDR1, UNLOCK_DATA1};
      2'd1: pfhc_cmd = {UNLOCK_ADDR2, UNLOCK_DATA2};
      2'd2: pfhc_cmd = {UNLOCK_ADDR1, last};
      default: pfhc_cmd = {a, last};
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_op = op;
    next_step = step;
    next_addr = addr_q;
    next_data = data_q;
    next_prev_poll = prev_poll;
    next_cnt = cnt;
    next_rdy = rdy;
    next_vld = 1'b0;
    next_err = err;
    next_idm = idm;
    next_rstn = rstn;
    next_wm = wm;
    next_pg_ok = pg_ok;
    next_rd = rd;
    next_page = page_q;
    next_start = 1'b0;
    next_isw = isw;
    next_keep = keep;
    next_wc = wc;
    next_ca = ca;
    next_cd = cd;
    next_alsb = alsb;
    case (st)
      PFHC_S_IDLE: begin
        if (req_valid && rdy) begin
          next_rdy = 1'b0;
          next_op = req_op;
          next_addr = req_addr;
          next_data = req_wdata;
          next_wm = word_mode;
          next_err = 1'b0;
          next_step = 2'd0;
          next_st = PFHC_S_CYC;
          case (req_op)
            PFHC_OP_READ: begin
              next_start = 1'b1;
              next_isw = 1'b0;
              next_keep = 1'b1;
              next_ca = word_mode ? req_addr : {1'b0, req_addr[23:1]};
              next_alsb = !word_mode && req_addr[0];
              // Same page while select stays low gets short wait
              next_wc = (pg_ok && req_page == page_q && word_mode == wm) ?
                        4'(PACC_CYC) : 4'(ACC_CYC);
              next_page = req_page;
              next_pg_ok = 1'b1;
              next_st = PFHC_S_WAIT;
            end
            PFHC_OP_HWRESET: begin
              next_rstn = 1'b0;
              next_cnt = 8'(RP_CYC);
              next_st = PFHC_S_RSTLO;
            end
            PFHC_OP_EXIT_ID: next_step = 2'd3;
            default: next_step = 2'd0;
          endcase
          if (req_op != PFHC_OP_READ) begin
            next_pg_ok = 1'b0;
          end
        end
      end
      PFHC_S_CYC: begin
        // Issue next command write of the sequence
        next_start = 1'b1;
        next_isw = 1'b1;
        next_keep = 1'b0;
        next_wc = 4'(WP_CYC - 1);
        if (op == PFHC_OP_EXIT_ID) begin
          {next_ca, next_cd} = {addr_q, CMD_RESET};
        end else begin
          {next_ca, next_cd} = pfhc_cmd(step, (step == 2'd3) ? data_q :
            ((op == PFHC_OP_PROGRAM) ? CMD_PROGRAM : CMD_IDENT), addr_q);
        end
        // Byte mode: commands keep their pin address, data splits off the LSB
        next_alsb = 1'b0;
        if (!wm && op == PFHC_OP_PROGRAM && step == 2'd3) begin
          next_ca = {1'b0, addr_q[23:1]};
          next_alsb = addr_q[0];
        end
        next_st = PFHC_S_WAIT;
      end
      PFHC_S_WAIT: begin
        if (cyc.done) begin
          if (op == PFHC_OP_READ) begin
            // Identifier codes sit on the low byte
            next_rd = (idm || !wm) ? {8'h00, cyc.rdata[7:0]} : cyc.rdata;
            next_vld = 1'b1;
            next_rdy = 1'b1;
            next_st = PFHC_S_IDLE;
          end else if (op == PFHC_OP_IDENT && step == 2'd2) begin
            next_idm = 1'b1;
            next_vld = 1'b1;
            next_rdy = 1'b1;
            next_st = PFHC_S_IDLE;
          end else if (op == PFHC_OP_EXIT_ID) begin
            next_idm = 1'b0;
            next_vld = 1'b1;
            next_rdy = 1'b1;
            next_st = PFHC_S_IDLE;
          end else if (step == 2'd3) begin
            // Poll status at the programmed address until toggling stops
            next_start = 1'b1;
            next_isw = 1'b0;
            next_keep = 1'b0;
            next_wc = 4'(ACC_CYC);
            next_cnt = POLL_LIMIT;
            next_prev_poll = 16'h0000;
            next_st = PFHC_S_POLL;
          end else begin
            next_step = step + 2'd1;
            next_st = PFHC_S_CYC;
          end
        end
      end
      PFHC_S_POLL: begin
        if (cyc.done) begin
          if (cyc.rdata[6] == prev_poll[6] && cnt != POLL_LIMIT) begin
            next_rd = cyc.rdata;
            next_err = (cyc.rdata[7:0] != data_q[7:0]);
            next_vld = 1'b1;
            next_rdy = 1'b1;
            next_st = PFHC_S_IDLE;
          end else if (cnt == 8'h00) begin
            // Stuck operation: flag error, caller may reset
            next_err = 1'b1;
            next_vld = 1'b1;
            next_rdy = 1'b1;
            next_st = PFHC_S_IDLE;
          end else begin
            next_prev_poll = cyc.rdata;
            next_cnt = cnt - 8'h01;
            next_start = 1'b1;
          end
        end
      end
      PFHC_S_RSTLO: begin
        if (cnt == 8'h00) begin
          next_rstn = 1'b1;
          next_cnt = 8'(RH_CYC);
          next_st = PFHC_S_RSTHI;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      PFHC_S_RSTHI: begin
        if (cnt == 8'h00) begin
          next_idm = 1'b0;
          next_vld = 1'b1;
          next_rdy = 1'b1;
          next_st = PFHC_S_IDLE;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_st = PFHC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= PFHC_S_IDLE;
      op <= PFHC_OP_READ;
      step <= 2'd0;
      addr_q <= 24'h000000;
      data_q <= 16'h0000;
      prev_poll <= 16'h0000;
      cnt <= 8'h00;
      rdy <= 1'b1;
      vld <= 1'b0;
      err <= 1'b0;
      idm <= 1'b0;
      rstn <= 1'b1;
      wm <= 1'b1;
      pg_ok <= 1'b0;
      rd <= 16'h0000;
      page_q <= 21'h000000;
      start <= 1'b0;
      isw <= 1'b0;
      keep <= 1'b0;
      wc <= 4'h0;
      ca <= 24'h000000;
      cd <= 16'h0000;
      alsb <= 1'b0;
    end else begin
      st <= next_st;
      op <= next_op;
      step <= next_step;
      addr_q <= next_addr;
      data_q <= next_data;
      prev_poll <= next_prev_poll;
      cnt <= next_cnt;
      rdy <= next_rdy;
      vld <= next_vld;
      err <= next_err;
      idm <= next_idm;
      rstn <= next_rstn;
      wm <= next_wm;
      pg_ok <= next_pg_ok;
      rd <= next_rd;
      page_q <= next_page;
      start <= next_start;
      isw <= next_isw;
      keep <= next_keep;
      wc <= next_wc;
      ca <= next_ca;
      cd <= next_cd;
      alsb <= next_alsb;
    end
  end

  assign req_ready = rdy;
  assign rsp_valid = vld;
  assign rsp_rdata = rd;
  assign rsp_error = err;
  assign id_active = idm;
  assign flash_reset_n = rstn;
  assign flash_width_sel = wm;
endmodule
`default_nettype wire

// ==== tb/pfhc_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfhc_checker
  import pfhc_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Host side
  input wire logic        req_valid,
  input wire pfhc_op_t    req_op,
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        word_mode,
  // Flash pins
  input wire logic        flash_sel_n,
  input wire logic        flash_gate_n,
  input wire logic        flash_wstrb_n,
  input wire logic        flash_reset_n,
  input wire logic        flash_width_sel,
  input wire logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic [15:0] flash_dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       acc;
  logic [7:0] low_cnt, next_low_cnt;
  logic [2:0] wr_cnt, next_wr_cnt;
  logic       in_prog, next_in_prog, wm_q, next_wm_q, wstrb_q;
  assign acc = req_valid && req_ready;
  // Saturating, so a stuck reset cannot wrap into a short pulse
  always_comb begin
    next_low_cnt = flash_reset_n ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
    next_wr_cnt = acc ? 3'h0 : wr_cnt + {2'h0, wstrb_q && !flash_wstrb_n};
    next_in_prog = acc ? (req_op == PFHC_OP_PROGRAM) : (in_prog && !rsp_valid);
    next_wm_q = acc ? word_mode : wm_q;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_cnt <= 8'h00;
      wr_cnt <= 3'h0;
      in_prog <= 1'b0;
      wm_q <= 1'b1;
      wstrb_q <= 1'b1;
    end else begin
      low_cnt <= next_low_cnt;
      wr_cnt <= next_wr_cnt;
      in_prog <= next_in_prog;
      wm_q <= next_wm_q;
      wstrb_q <= flash_wstrb_n;
    end
  end
  sequence s_wstart;
    $fell(flash_wstrb_n);
  endsequence
  sequence s_wlow;
    (!flash_wstrb_n)[*2] ##1 flash_wstrb_n;
  endsequence
  property p_wr_pulse;
    s_wstart |-> s_wlow;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");
  property p_read_cyc;
    !flash_gate_n |-> flash_wstrb_n && flash_dq_oe[14:0] == 15'h0000 &&
                      (!flash_dq_oe[15] || !flash_width_sel);
  endproperty
  a_read_cyc: assert property (p_read_cyc) else $error("read cycle pins wrong");
  property p_write_cyc;
    !flash_wstrb_n |-> flash_gate_n && !flash_sel_n;
  endproperty
  a_write_cyc: assert property (p_write_cyc) else $error("write cycle pins wrong");
  property p_wr_hold;
    !flash_wstrb_n |=> $stable(flash_addr) && $stable(flash_dq_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write address or data moved");
  property p_byte_float;
    !flash_width_sel |-> flash_dq_oe[14:8] == 7'h00;
  endproperty
  a_byte_float: assert property (p_byte_float) else $error("upper pins driven in byte mode");
  property p_width;
    acc |=> ##[0:2] flash_width_sel == wm_q;
  endproperty
  a_width: assert property (p_width) else $error("width select not following mode");
  property p_hw_pulse;
    $rose(flash_reset_n) |-> low_cnt >= 8'(RP_CYC);
  endproperty
  a_hw_pulse: assert property (p_hw_pulse) else $error("reset pulse too short");
  property p_prog_four;
    in_prog && $fell(flash_gate_n) |-> wr_cnt == 3'h4;
  endproperty
  a_prog_four: assert property (p_prog_four) else $error("program not four writes");
  property p_ready;
    acc |=> !req_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready did not drop");
  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("response longer than a cycle");
endmodule
bind pfhc_top pfhc_checker i_chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
  .req_op(req_op), .req_ready(req_ready), .rsp_valid(rsp_valid), .word_mode(word_mode),
  .flash_sel_n(flash_sel_n), .flash_gate_n(flash_gate_n), .flash_wstrb_n(flash_wstrb_n),
  .flash_reset_n(flash_reset_n), .flash_width_sel(flash_width_sel),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));
`default_nettype wire

// ==== tb/pfhc_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfhc_flash_model
  import pfhc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE  = 8'h5e, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h7d, // Arbitrary value
  parameter int         BUSY_POLLS  = 3
) (
  // Control pins
  input  wire logic        sel_n,
  input  wire logic        gate_n,
  input  wire logic        wstrb_n,
  input  wire logic        reset_n,
  input  wire logic        width_sel,
  input  wire logic [23:0] addr,
  // Host drive and resolved bus
  input  wire logic [15:0] host_dq,
  input  wire logic [15:0] host_oe,
  output logic [15:0]      bus
);
  logic [15:0] mem [logic [23:0]];
  logic [15:0] pdat, d, word, drv, dev_oe;
  logic [23:0] pa, wa, prev_a;
  logic        busy = 0, ident = 0, tog = 0, flip = 0, acc_ok = 0, open_pg = 0, wb, plow;
  int          step = 0, polls = 0, gen = 0, lat = ADDRESS_ACCESS_LATENCY_NS;
  time         fall_t = 0;
  wire rd_act = !sel_n && !gate_n && wstrb_n && reset_n;
  wire wr_act = !sel_n && !wstrb_n && gate_n && reset_n;
  assign dev_oe = !rd_act ? 16'h0000 : (width_sel ? 16'hffff : 16'h00ff);
  // Undriven lines wander so a stale value never passes
  assign bus = (dev_oe & drv) | (~dev_oe & host_oe & host_dq) | (~dev_oe & ~host_oe & {8{flip, !flip}});
  function automatic logic [15:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'hc3c3);
  endfunction
  task automatic arm(input int g, input int lat);
    #lat;
    if (g == gen) acc_ok = 1'b1;
  endtask
  always #7 flip = !flip;
  always @(sel_n or addr) begin
    gen = gen + 1;
    acc_ok = 1'b0;
    if (!sel_n) begin
      // A select fall in this same step is never a page hit
      lat = (open_pg && $time != fall_t && addr[23:3] == prev_a[23:3]) ?
            PAGE_ACCESS_LATENCY_NS : ADDRESS_ACCESS_LATENCY_NS;
      if (!open_pg) fall_t = $time;
      fork
        arm(gen, lat);
      join_none
      open_pg = 1'b1;
      prev_a = addr;
    end else begin
      open_pg = 1'b0;
    end
  end
  always @* begin
    if (busy) word = {8'h00, ~pdat[7], tog, 6'h00};
    else if (ident) word = {8'h00, addr[1:0] == 2'h0 ? MAKER_CODE : addr[1:0] == 2'h1 ? DEVICE_CODE : 8'h00};
    else word = rd(addr);
    if (!width_sel && !busy && !ident) word[7:0] = bus[15] ? word[15:8] : word[7:0];
    drv = acc_ok ? word : ~word;
  end
  always @(posedge wr_act) begin
    wa = addr;
    wb = bus[15];
  end
  always @(negedge wr_act) begin
    d = width_sel ? bus : {8'h00, bus[7:0]};
    if (busy) step = 0;
    else if (d == CMD_RESET) begin ident = 0; step = 0; end
    else if (step == 3) begin pa = wa; pdat = d; plow = wb; busy = 1; polls = 0; step = 0; end
    else if (step == 0 && wa[10:0] == UNLOCK_ADDR1[10:0] && d == UNLOCK_DATA1) step = 1;
    else if (step == 1 && wa[10:0] == UNLOCK_ADDR2[10:0] && d == UNLOCK_DATA2) step = 2;
    else if (step == 2 && wa[10:0] == UNLOCK_ADDR1[10:0] && d == CMD_PROGRAM && !ident) step = 3;
    else if (step == 2 && wa[10:0] == UNLOCK_ADDR1[10:0] && d == CMD_IDENT) begin ident = 1; step = 0; end
    else step = 0;
  end
  always @(posedge rd_act) if (busy) begin
    tog = !tog;
    polls = polls + 1;
    if (polls == BUSY_POLLS) begin
      mem[pa] = rd(pa) & (width_sel ? pdat : (plow ? {pdat[7:0], 8'hff} : {8'hff, pdat[7:0]}));
      busy = 0;
    end
  end
  always @(negedge reset_n) begin
    busy = 0;
    ident = 0;
    step = 0;
  end
endmodule
`default_nettype wire

// ==== tb/pfhc_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pfhc_top_test
  import pfhc_pkg::*;
;
  localparam logic [7:0] MAKER_CODE  = 8'h5e; // Arbitrary value
  localparam logic [7:0] DEVICE_CODE = 8'h7d; // Arbitrary value
  logic        clk_sys, rst, req_valid, word_mode, req_ready, rsp_valid, rsp_error, id_active;
  logic        flash_sel_n, flash_gate_n, flash_wstrb_n, flash_reset_n, flash_width_sel;
  pfhc_op_t    req_op;
  logic [23:0] req_addr, flash_addr;
  logic [15:0] req_wdata, rsp_rdata, flash_dq_i, flash_dq_o, flash_dq_oe, rdata;
  int          errors = 0, tests_run = 0;
  pfhc_top i_dut (.clk_sys, .rst, .req_valid, .req_op, .req_addr, .req_wdata, .word_mode,
    .req_ready, .rsp_valid, .rsp_rdata, .rsp_error, .id_active, .flash_sel_n, .flash_gate_n,
    .flash_wstrb_n, .flash_reset_n, .flash_width_sel, .flash_addr, .flash_dq_i, .flash_dq_o,
    .flash_dq_oe);
  pfhc_flash_model #(.MAKER_CODE(MAKER_CODE), .DEVICE_CODE(DEVICE_CODE), .BUSY_POLLS(3)) i_flash (
    .sel_n(flash_sel_n), .gate_n(flash_gate_n), .wstrb_n(flash_wstrb_n), .reset_n(flash_reset_n),
    .width_sel(flash_width_sel), .addr(flash_addr), .host_dq(flash_dq_o), .host_oe(flash_dq_oe),
    .bus(flash_dq_i));
  task automatic report_and_stop();
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(inout int n, input int lim);
    @(posedge clk_sys);
    #1;
    n++;
    if (n > lim) begin
      errors++;
      report_and_stop();
    end
  endtask
  function automatic logic [15:0] init_w(input logic [23:0] a);
    return a[15:0] ^ 16'hc3c3;
  endfunction
  // Blocking request: waits for ready, holds one edge, waits for the response
  task automatic do_op(input pfhc_op_t op, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) tick(n, 200);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    tick(n, 200);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) tick(n, 4000);
    rdata = rsp_rdata;
  endtask
  task automatic t_read();
    do_op(PFHC_OP_READ, 24'h123456, 16'h0000);
    chk(rdata, init_w(24'h123456));
    do_op(PFHC_OP_READ, 24'hfffff8, 16'h0000);
    chk(rdata, init_w(24'hfffff8));
  endtask
  task automatic t_page();
    logic [23:0] a[5] = '{24'h040008, 24'h04000d, 24'h04000f, 24'h040010, 24'h040017};
    foreach (a[i]) begin
      do_op(PFHC_OP_READ, a[i], 16'h0000);
      chk(rdata, init_w(a[i]));
    end
  endtask
  task automatic t_prog();
    do_op(PFHC_OP_PROGRAM, 24'h020101, 16'h4242);
    chk({15'h0000, rsp_error}, 16'h0000);
    do_op(PFHC_OP_READ, 24'h020101, 16'h0000);
    chk(rdata, 16'h4242);
    do_op(PFHC_OP_PROGRAM, 24'h020101, 16'hffc0);
    do_op(PFHC_OP_READ, 24'h020101, 16'h0000);
    chk(rdata, 16'h4240);
    do_op(PFHC_OP_PROGRAM, 24'h7f0003, 16'h0000);
    do_op(PFHC_OP_READ, 24'h7f0003, 16'h0000);
    chk(rdata, 16'h0000);
  endtask
  task automatic t_ident();
    do_op(PFHC_OP_IDENT, 24'h000000, 16'h0000);
    chk({15'h0000, id_active}, 16'h0001);
    do_op(PFHC_OP_READ, 24'h000000, 16'h0000);
    chk(rdata, {8'h00, MAKER_CODE});
    do_op(PFHC_OP_READ, 24'h000001, 16'h0000);
    chk(rdata, {8'h00, DEVICE_CODE});
    do_op(PFHC_OP_READ, 24'h7f0002, 16'h0000);
    chk(rdata, 16'h0000);
    do_op(PFHC_OP_EXIT_ID, 24'h000000, 16'h0000);
    chk({15'h0000, id_active}, 16'h0000);
    do_op(PFHC_OP_READ, 24'h000010, 16'h0000);
    chk(rdata, init_w(24'h000010));
  endtask
  // Byte addresses: word address above, pin 15 picks the half
  task automatic t_byte();
    word_mode = 1'b0;
    do_op(PFHC_OP_READ, 24'h000021, 16'h0000);
    chk({8'h00, rdata[7:0]}, init_w(24'h000010) >> 8);
    do_op(PFHC_OP_PROGRAM, 24'h000040, 16'h0041);
    do_op(PFHC_OP_READ, 24'h000040, 16'h0000);
    chk({8'h00, rdata[7:0]}, 16'h0041);
    word_mode = 1'b1;
  endtask
  task automatic t_hwreset();
    do_op(PFHC_OP_IDENT, 24'h000000, 16'h0000);
    do_op(PFHC_OP_HWRESET, 24'h000000, 16'h0000);
    do_op(PFHC_OP_READ, 24'h000001, 16'h0000);
    chk(rdata, init_w(24'h000001));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = PFHC_OP_READ;
    req_addr = 24'h000000;
    req_wdata = 16'h0000;
    word_mode = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_read();
    t_page();
    t_prog();
    t_ident();
    t_byte();
    t_hwreset();
    report_and_stop();
  end
endmodule
`default_nettype wire
